/* File: dv/rsse_reset_source_properties.sv */
// Assertions on the ports of the reset-cause register block.
// Assumes the bind below onto the block's top module.
`timescale 1ns/100ps
module rsse_reset_source_properties #(parameter int HOLD_CYCLES = 3) (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       sfrWrite,
  input wire logic       sfrRead,
  input wire logic       systemReset,
  input wire logic       flashFault,
  input wire logic       watchdogOverflow,
  input wire logic       missingClockTimeout,
  input wire logic       comparatorResetEnable,
  input wire logic       missingClockEnable,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata
);
  // Hold figure below matches the HOLD_CYCLES of 3 set by the bench
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence rdReg; sfrRead && sfrAddr == 8'hef; endsequence
  sequence wdtEntry; watchdogOverflow && !systemReset; endsequence
  chk_flash_reset: assert property (flashFault |=> systemReset) else $error("no flash reset");
  chk_wdt_reset: assert property (watchdogOverflow |=> systemReset) else $error("no watchdog reset");
  chk_sw_force: assert property (sfrWrite && sfrAddr == 8'hef && sfrWdata[4] |=> ##1 systemReset)
    else $error("no forced reset");
  chk_mcd_reset: assert property (missingClockEnable && missingClockTimeout |=> systemReset)
    else $error("no clock reset");
  chk_hold_time: assert property ($rose(systemReset) |-> systemReset[*3]) else $error("reset too short");
  chk_entry_disarm: assert property ($rose(systemReset) |-> !comparatorResetEnable && !missingClockEnable)
    else $error("arm kept in reset");
  chk_idle_read: assert property (!(sfrRead && sfrAddr == 8'hef) |=> sfrRdata == 8'h00)
    else $error("stray read data");
  chk_wdt_cause: assert property (wdtEntry ##1 rdReg |=> sfrRdata[3] && !sfrRdata[1])
    else $error("bad watchdog cause");
endmodule : rsse_reset_source_properties
bind rsse_reset_source rsse_reset_source_properties #(.HOLD_CYCLES(HOLD_CYCLES)) rsse_reset_source_properties_i (.*);

/* File: dv/rsse_reset_source_tb.sv */
// Self-checking bench for the reset-cause register block.
// Assumes the property checker is bound from its own file.
`timescale 1ns/100ps
module rsse_reset_source_tb;
  logic       clock = 1'h0, rst_n = 1'h0, sfrWrite = 1'h0, sfrRead = 1'h0, flashFault = 1'h0;
  logic       watchdogOverflow = 1'h0, missingClockTimeout = 1'h0, supplyBelow = 1'h0;
  logic       external_reset_pin_n = 1'h1, comparatorOut_n = 1'h1;
  logic       systemReset, comparatorResetEnable, missingClockEnable, supplyResetEnable;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, d, m;
  int         fails = 0, nChecks = 0, cycles = 0, seed = 90, expCause;
  int         rstCycles = 0, base, expLen;
  int         expQ[$];
  localparam int HOLD = 3;
  wire  [7:0] en = {5'h00, comparatorResetEnable, missingClockEnable, supplyResetEnable};
  rsse_reset_source #(.HOLD_CYCLES(HOLD)) rsse_reset_source_i (
    .clock                 (clock),
    .rst_n                 (rst_n),
    .sfrAddr               (sfrAddr),
    .sfrWrite              (sfrWrite),
    .sfrRead               (sfrRead),
    .sfrWdata              (sfrWdata),
    .sfrRdata              (sfrRdata),
    .external_reset_pin_n  (external_reset_pin_n),
    .comparatorOut_n       (comparatorOut_n),
    .supplyBelow           (supplyBelow),
    .missingClockTimeout   (missingClockTimeout),
    .watchdogOverflow      (watchdogOverflow),
    .flashFault            (flashFault),
    .systemReset           (systemReset),
    .comparatorResetEnable (comparatorResetEnable),
    .missingClockEnable    (missingClockEnable),
    .supplyResetEnable     (supplyResetEnable)
  );
  always #2 clock = ~clock;
  task automatic cyc;
    @(posedge clock);
    #1;
  endtask : cyc
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    nChecks++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk
  // One access of whole values, never read-modify-write
  // Idle cycle after it, so strobes never toggle twice in one step
  task automatic bus(logic w, logic [7:0] a, logic [7:0] v);
    {sfrWrite, sfrRead, sfrAddr, sfrWdata} = {w, !w, a, v};
    cyc;
    d = sfrRdata;
    {sfrWrite, sfrRead} = 2'h0;
    cyc;
  endtask : bus
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge clock)
  begin
    cycles++;
    if (systemReset === 1'h1) rstCycles++;
    if (cycles == 2000) // Run needs under a hundred cycles
    begin
      fails++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (3) @(posedge clock);
    #1 rst_n = 1'h1;
    bus(1'h0, 8'hef, 8'h00);
    chk("cause", 8'h02, d);
    chk("enables", 8'h01, en);
    bus(1'h1, 8'hef, 8'h26); // supply is steady here
    chk("enables", 8'h07, en);
    bus(1'h1, 8'($random(seed)) & 8'h7f, 8'($random(seed)));
    chk("enables", 8'h07, en);
    bus(1'h0, 8'($random(seed)) & 8'h7f, 8'h00);
    chk("unmapped", 8'h00, d);
    bus(1'h1, 8'hef, 8'h22);
    chk("enables", 8'h05, en);
    bus(1'h0, 8'hef, 8'h00);
    chk("cause", 8'h02, d);
    for (int i = 0; i < 7; i++)
    begin
      expQ.push_back((i == 1) ? 2 : 1 << i);
      base = rstCycles;
      case (i)
        0: external_reset_pin_n = 1'h0;
        1: supplyBelow = 1'h1;
        2: begin bus(1'h1, 8'hef, 8'h04); missingClockTimeout = 1'h1; end
        3: begin watchdogOverflow = 1'h1; cyc; bus(1'h0, 8'hef, 8'h00); end
        4: bus(1'h1, 8'hef, 8'h10);
        5: begin bus(1'h1, 8'hef, 8'h20); comparatorOut_n = 1'h0; end
        default: flashFault = 1'h1;
      endcase
      repeat (4) cyc;
      {flashFault, watchdogOverflow, missingClockTimeout, supplyBelow} = 4'h0;
      {external_reset_pin_n, comparatorOut_n} = 2'h3;
      for (int k = 0; k < 40 && systemReset !== 1'h0; k++) cyc;
      bus(1'h0, 8'hef, 8'h00);
      expCause = expQ.pop_front();
      // Other flags are undefined after a supply reset
      m = (i == 1) ? 8'h02 : 8'hff;
      chk("cause", 8'(expCause) & m, d & m);
      // Armed sources disarm at entry, so they request for one cycle only
      expLen = HOLD - 1 + ((i == 3) ? 7 : (i == 2 || i == 4 || i == 5) ? 1 : 4);
      chk("reset cycles", 8'(expLen), 8'(rstCycles - base));
    end
    print_verdict;
  end
endmodule : rsse_reset_source_tb

/* File: logic/rsse_pkg.sv */
// Constants for the reset-cause and source-enable register block.
// Assumes a single system clock and an 8-bit special-function register port.
package rsse_pkg;
  localparam logic [7:0] RSSE_REG_ADDR       = 8'hef;
  localparam int         RSSE_BIT_FLASH      = 6;
  localparam int         RSSE_BIT_COMPARATOR = 5;
  localparam int         RSSE_BIT_SOFTWARE   = 4;
  localparam int         RSSE_BIT_WATCHDOG   = 3;
  localparam int         RSSE_BIT_MISSCLK    = 2;
  localparam int         RSSE_BIT_POWER      = 1;
  localparam int         RSSE_BIT_PIN        = 0;
  localparam int         RSSE_CAUSE_WIDTH    = 7;
  // Power-on leaves only the power/supply cause set
  localparam logic [6:0] RSSE_CAUSE_POR      = 7'h02;
  localparam logic       RSSE_SUPPLY_EN_POR  = 1'b1;
  localparam logic       RSSE_CMP_EN_RESET   = 1'b0;
  localparam logic       RSSE_MCD_EN_RESET   = 1'b0;
  localparam logic [7:0] RSSE_RDATA_RESET    = 8'h00;
  localparam int         RSSE_CLOCK_PERIOD_PS = 4000;
  localparam int         RSSE_RESET_HOLD_NS   = 100;
  // Least time, so round up
  localparam int         RSSE_RESET_HOLD_CYCLES =
    (RSSE_RESET_HOLD_NS * 1000 + RSSE_CLOCK_PERIOD_PS - 1) / RSSE_CLOCK_PERIOD_PS;
endpackage : rsse_pkg

/* File: logic/rsse_reset_source.sv */
// Reset-cause status and reset-source enable register with the system reset request.
// Assumes rst_n is the power-on reset; system resets it requests clear the comparator and missing-clock arming and replace the cause flags.
`timescale 1ns/100ps
// How it works
// R01 - Bit 6 reads 1 when a flash fault caused the last reset.
// R02 - Bit 5 reads 1 when the comparator caused the last reset.
// R03 - Writing 1 to bit 5 arms comparator; low output then resets.
// R04 - Bit 4 reads 1 when a software write caused the last reset.
// R05 - Writing 1 to bit 4 forces a system reset two cycles later.
// R06 - Bit 3 reads 1 when watchdog overflow caused the last reset.
// R07 - Bit 2 reads 1 when missing-clock timeout caused the last reset.
// R08 - Writing 1 to bit 2 arms the missing-clock detector as reset.
// R09 - Bit 1 reads 1 after power-on or supply-monitor reset.
// R10 - Writing 1 to bit 1 selects the supply monitor as reset source.
// R11 - Writes only set enables and force; they never touch cause flags.
// R12 - Reads always return cause flags, never written enables.
// R13 - Software should avoid read-modify-write on this register.
// R14 - With bit 1 set, the other cause flags are undefined.
// R15 - Software sets bit 1 only once the supply monitor is stable.
// R16 - Bit 0 reads 1 after a reset from the external pin.
// R17 - Every reset except power-on or supply clears bit 1.
// R18 - Writing 0 to bit 2 disables the missing-clock detector.
// R19 - Flags of sources that did not cause the last reset read 0.
module rsse_reset_source #(
  parameter int HOLD_CYCLES = rsse_pkg::RSSE_RESET_HOLD_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic       sfrRead,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  input  wire logic       external_reset_pin_n,
  input  wire logic       comparatorOut_n,
  input  wire logic       supplyBelow,
  input  wire logic       missingClockTimeout,
  input  wire logic       watchdogOverflow,
  input  wire logic       flashFault,
  output logic            systemReset,
  output logic            comparatorResetEnable,
  output logic            missingClockEnable,
  output logic            supplyResetEnable
);
  localparam int CW = rsse_pkg::RSSE_CAUSE_WIDTH;
  // Sixteen bits leave room for a faster clock
  localparam logic [15:0] HOLD_LOAD = 16'(HOLD_CYCLES);

  logic [2:0]    pinSync;
  logic          pinLow;
  logic          cmpLow;
  logic          supplyLow;
  logic [CW-1:0] cause_reg;
  logic [CW-1:0] cause_next;
  logic [CW-1:0] causeMerged;
  logic [CW-1:0] request;
  logic          anyRequest;
  logic          resetEntry;
  logic          regWrite;
  logic          regRead;
  logic          swForce_reg;
  logic          swForce_next;
  logic [15:0]   hold_reg;
  logic [15:0]   hold_next;
  logic [15:0]   holdStep;
  logic          holdRunning;
  logic          reset_next;
  logic          cmpEn_next;
  logic          mcdEn_next;
  logic          supplyEn_next;
  logic [7:0]    readWord;
  logic [7:0]    rdata_next;

  // One address decode serves both the read and the write path
  function automatic logic reg_hit(
    input logic [7:0] addr
  );
    return addr == rsse_pkg::RSSE_REG_ADDR;
  endfunction : reg_hit

  // Entry to a reset beats a write in the same cycle
  function automatic logic arm_next(
    input logic entry,
    input logic cleared,
    input logic write,
    input logic written,
    input logic current
  );
    if (entry)
      return cleared;
    else if (write)
      return written;
    else
      return current;
  endfunction : arm_next

  // Pins are asynchronous to the system clock
  // Reset to idle levels, else a false reset follows power-on
  rsse_sync2 #(
    .WIDTH      (3),
    .RESET_BITS (3'h6)
  ) u_pin_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .asyncIn ({external_reset_pin_n, comparatorOut_n, supplyBelow}),
    .syncOut (pinSync)
  );

  assign pinLow    = ~pinSync[2];
  assign cmpLow    = ~pinSync[1];
  assign supplyLow = pinSync[0];

  assign regWrite = sfrWrite & reg_hit(sfrAddr);
  assign regRead  = sfrRead & reg_hit(sfrAddr);

  // One request bit per cause, in register bit order
  assign request[rsse_pkg::RSSE_BIT_FLASH]      = flashFault;                        // [R01]
  assign request[rsse_pkg::RSSE_BIT_COMPARATOR] = comparatorResetEnable & cmpLow;    // [R02] [R03]
  assign request[rsse_pkg::RSSE_BIT_SOFTWARE]   = swForce_reg;                       // [R04]
  assign request[rsse_pkg::RSSE_BIT_WATCHDOG]   = watchdogOverflow;                  // [R06]
  assign request[rsse_pkg::RSSE_BIT_MISSCLK]    = missingClockEnable & missingClockTimeout; // [R07] [R08]
  assign request[rsse_pkg::RSSE_BIT_POWER]      = supplyResetEnable & supplyLow;     // [R09] [R10]
  assign request[rsse_pkg::RSSE_BIT_PIN]        = pinLow;                            // [R16]
  assign anyRequest = |request;
  assign resetEntry = anyRequest & ~systemReset;

  // Fresh reset replaces every flag, so absent sources read 0 and bit 1 clears
  assign causeMerged = cause_reg | request;
  assign cause_next  = resetEntry ? request                                  // [R17] [R19]
                     : (anyRequest ? causeMerged : cause_reg);               // [R14]

  // Reset stays up while a source is active, then for the least hold time
  assign holdRunning = (hold_reg != 16'h0000);
  assign holdStep    = holdRunning ? hold_reg - 16'h0001 : 16'h0000;
  assign hold_next   = anyRequest ? HOLD_LOAD : holdStep;
  assign reset_next  = anyRequest | (hold_next != 16'h0000);

  // Force is a one-cycle strobe, so it never reads back as a control
  assign swForce_next = regWrite & sfrWdata[rsse_pkg::RSSE_BIT_SOFTWARE];    // [R05]

  // Comparator and detector arming drop with each system reset
  assign cmpEn_next = arm_next(resetEntry,
                               rsse_pkg::RSSE_CMP_EN_RESET,
                               regWrite,
                               sfrWdata[rsse_pkg::RSSE_BIT_COMPARATOR],
                               comparatorResetEnable);                        // [R03] [R11]
  assign mcdEn_next = arm_next(resetEntry,
                               rsse_pkg::RSSE_MCD_EN_RESET,
                               regWrite,
                               sfrWdata[rsse_pkg::RSSE_BIT_MISSCLK],
                               missingClockEnable);                           // [R08] [R18]
  // Supply selection survives, else a dip would disarm its own guard
  assign supplyEn_next = regWrite ? sfrWdata[rsse_pkg::RSSE_BIT_POWER] : supplyResetEnable; // [R10] [R11]

  // Read path only ever sees the causes; reserved bit 7 reads 0
  // Read data stands one cycle, then returns to zero
  assign readWord   = {1'h0, cause_reg};
  assign rdata_next = regRead ? readWord : rsse_pkg::RSSE_RDATA_RESET;       // [R12]

  // Only power-on loads the reset value; at system reset entry the flags are replaced by the requests
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cause_reg <= rsse_pkg::RSSE_CAUSE_POR;                                 // [R09]
    else
      cause_reg <= cause_next;                                               // [R11]
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      swForce_reg <= 1'h0;
    else
      swForce_reg <= swForce_next;                                           // [R05]
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hold_reg <= 16'h0000;
    else
      hold_reg <= hold_next;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      systemReset <= 1'h0;
    else
      systemReset <= reset_next;                                             // [R05]
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      comparatorResetEnable <= rsse_pkg::RSSE_CMP_EN_RESET;
    else
      comparatorResetEnable <= cmpEn_next;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      missingClockEnable <= rsse_pkg::RSSE_MCD_EN_RESET;
    else
      missingClockEnable <= mcdEn_next;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      supplyResetEnable <= rsse_pkg::RSSE_SUPPLY_EN_POR;
    else
      supplyResetEnable <= supplyEn_next;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sfrRdata <= rsse_pkg::RSSE_RDATA_RESET;
    else
      sfrRdata <= rdata_next;
  end
endmodule : rsse_reset_source

/* File: logic/rsse_sync2.sv */
// Two-flop synchroniser for a vector of unrelated levels.
// Assumes each bit is a slow level; no bus coherence is given.
`timescale 1ns/100ps
module rsse_sync2 #(
  parameter int                 WIDTH      = 1,
  parameter logic [WIDTH-1:0]   RESET_BITS = '0
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_reg <= RESET_BITS;
      syncOut    <= RESET_BITS;
    end
    else
    begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end
endmodule : rsse_sync2
